/* pad_route_pkg.sv */
/*
 Constants of the pad routing and display control register bank.
 Assumes a 32-bit AHB-Lite bus whose low address bits select the register.
*/
// Contract
// [R1] Write-data bit n+16 enables writing bit n
// [R2] Data pad: link, serial, or software owner
// [R3] Clock pad: link, serial, or software owner
// [R4] Hot-plug pad software driven when bit 13
// [R5] Consumer pad software driven when bit 12
// [R6] Bit 11 gives shared SRAM to encoder
// [R7] Standby source: signal, clock enable, or either of them
// [R8] Bit 8 powers the PHY PLL down
// [R9] Bit 7 enables PHY parallel data
// [R10] Bits 5:3 set UART RTS polarity
// [R11] Bits 2:0 set UART CTS polarity
// [R12] Second control register decoded at 0x410
// [R13] Main control register decoded at 0x40C
// [R14] Software enable bit one makes pad input
// [R15] Mask half and bit 6 read zero
package pad_route_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_PAD_ROUTE = 12'h40C;
   localparam logic [11:0] OFF_SOC_FOUR = 12'h410;
   localparam logic [11:0] OFF_PAD_SW = 12'h420;
   localparam int MASK_LSB = 16;
   localparam int BIT_DATA_OVR = 15;
   localparam int BIT_CLOCK_OVR = 14;
   localparam int BIT_HOTPLUG_OVR = 13;
   localparam int BIT_CONSUMER_OVR = 12;
   localparam int BIT_SRAM_OWNER = 11;
   localparam int STANDBY_LSB = 9;
   localparam int BIT_PLL_PD = 8;
   localparam int BIT_PDATA_EN = 7;
   localparam int RTS_LSB = 3;
   localparam int CTS_LSB = 0;
   localparam logic [15:0] PAD_ROUTE_WRITABLE = 16'hFFBF;
   localparam logic [15:0] PAD_SW_WRITABLE = 16'h03FF;
   // Software pad register fields
   localparam int BIT_HOTPLUG_OE = 0;
   localparam int BIT_HOTPLUG_LVL = 1;
   localparam int BIT_CONSUMER_OE = 2;
   localparam int BIT_CONSUMER_LVL = 3;
   localparam int BIT_DATA_OE = 4;
   localparam int BIT_DATA_LVL = 5;
   localparam int BIT_CLOCK_OE = 6;
   localparam int BIT_CLOCK_LVL = 7;
   localparam int BIT_DATA_SERIAL = 8;
   localparam int BIT_CLOCK_SERIAL = 9;
   localparam int PAD_LEVEL_LSB = 12;
   localparam logic [15:0] RESET_VALUE = 16'h0000;
   localparam logic [1:0] STBY_SIGNAL = 2'h0;
   localparam logic [1:0] STBY_CLK_EN = 2'h1;
   localparam logic [1:0] STBY_EITHER = 2'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : pad_route_pkg

/* soc_pad_route_control_reg.sv */
/*
 Pad routing, SRAM owner, standby source, PHY and UART polarity control
 register bank behind an AHB-Lite slave port.
 Assumes single word transfers and asynchronous pad input levels.
*/
`timescale 1ns/1ps
`default_nettype none
module soc_pad_route_control_reg
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [pad_route_pkg::ADDR_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_dl_data_out,
   input wire logic i_dl_data_oe,
   input wire logic i_dl_clock_out,
   input wire logic i_dl_clock_oe,
   input wire logic i_dl_hotplug_out,
   input wire logic i_dl_hotplug_oe,
   input wire logic i_dl_consumer_out,
   input wire logic i_dl_consumer_oe,
   input wire logic i_i2c_data_out,
   input wire logic i_i2c_data_oe,
   input wire logic i_i2c_clock_out,
   input wire logic i_i2c_clock_oe,
   input wire logic [3:0] i_pad_in,
   output logic [3:0] o_pad_level,
   output logic o_data_pad_5v_out,
   output logic o_data_pad_5v_oe,
   output logic o_clock_pad_5v_out,
   output logic o_clock_pad_5v_oe,
   output logic o_hotplug_pad_5v_out,
   output logic o_hotplug_pad_5v_oe,
   output logic o_consumer_ctl_pad_5v_out,
   output logic o_consumer_ctl_pad_5v_oe,
   input wire logic i_disp_standby,
   input wire logic i_disp_bus_clk_en,
   output logic o_disp_standby,
   output logic o_sram_owner_select,
   output logic o_phy_pll_power_down,
   output logic o_phy_pdata_en,
   output logic [2:0] o_uart_rts_pol,
   output logic [2:0] o_uart_cts_pol,
   output logic [15:0] o_soc_control_four
);
   import pad_route_pkg::*;

   // ****************************************
   // Bus slave
   // ****************************************
   logic dp_write;
   logic [ADDR_W-1:0] dp_addr;
   logic [15:0] pad_route;
   logic [15:0] soc_four;
   logic [15:0] pad_sw;
   logic [3:0] pad_s1;
   logic [3:0] pad_s2;
   logic [3:0] pad_s3;
   logic [3:0] pad_lvl;

   function automatic logic [15:0] masked(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [15:0] writable);
      logic [15:0] en;
      en = wd[31:MASK_LSB] & writable;
      masked = (old & ~en) | (wd[15:0] & en);
   endfunction : masked

   wire addr_take = i_hsel && i_htrans == HTRANS_NONSEQ && i_hready;
   wire wr_route = dp_write && dp_addr == OFF_PAD_ROUTE; // R13
   wire wr_four = dp_write && dp_addr == OFF_SOC_FOUR; // R12
   wire wr_sw = dp_write && dp_addr == OFF_PAD_SW;
   wire [15:0] next_pad_route = wr_route ?
      masked(pad_route, i_hwdata, PAD_ROUTE_WRITABLE) : pad_route; // R1
   wire [15:0] next_soc_four = wr_four ? masked(soc_four, i_hwdata, '1) : soc_four; // R1
   wire [15:0] next_pad_sw = wr_sw ? masked(pad_sw, i_hwdata, PAD_SW_WRITABLE) : pad_sw;
   wire [15:0] sw_view = {pad_lvl, next_pad_sw[PAD_LEVEL_LSB-1:0]};
   wire [15:0] read_low = (i_haddr == OFF_PAD_ROUTE) ? next_pad_route :
                          (i_haddr == OFF_SOC_FOUR) ? next_soc_four :
                          (i_haddr == OFF_PAD_SW) ? sw_view : RESET_VALUE;
   wire [31:0] next_hrdata = {16'h0000, read_low}; // R15

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         dp_write <= 1'b0;
         dp_addr <= '0;
         o_hrdata <= 32'h00000000;
         o_hreadyout <= 1'b0;
         o_hresp <= 1'b0;
      end
      else
      begin
         dp_write <= addr_take && i_hwrite;
         dp_addr <= i_haddr;
         o_hrdata <= (addr_take && !i_hwrite) ? next_hrdata : 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pad_route <= RESET_VALUE; // R15
         soc_four <= RESET_VALUE;
         pad_sw <= RESET_VALUE;
      end
      else
      begin
         pad_route <= next_pad_route;
         soc_four <= next_soc_four;
         pad_sw <= next_pad_sw;
      end
   end

   // ****************************************
   // Pad input synchronisers
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pad_s1 <= 4'h0;
         pad_s2 <= 4'h0;
         pad_s3 <= 4'h0;
         pad_lvl <= 4'h0;
      end
      else
      begin
         pad_s1 <= i_pad_in;
         pad_s2 <= pad_s1;
         pad_s3 <= pad_s2;
         pad_lvl <= (pad_s2 & pad_s3) | (pad_lvl & (pad_s2 ^ pad_s3));
      end
   end

   // ****************************************
   // Pad routing
   // ****************************************
   wire data_ovr = pad_route[BIT_DATA_OVR];
   wire clock_ovr = pad_route[BIT_CLOCK_OVR];
   wire data_ser = pad_sw[BIT_DATA_SERIAL];
   wire clock_ser = pad_sw[BIT_CLOCK_SERIAL];
   wire next_data_out = data_ovr ? pad_sw[BIT_DATA_LVL] :
                        data_ser ? i_i2c_data_out : i_dl_data_out; // R2
   wire next_data_oe = data_ovr ? !pad_sw[BIT_DATA_OE] :
                       data_ser ? i_i2c_data_oe : i_dl_data_oe; // R2 R14
   wire next_clock_out = clock_ovr ? pad_sw[BIT_CLOCK_LVL] :
                         clock_ser ? i_i2c_clock_out : i_dl_clock_out; // R3
   wire next_clock_oe = clock_ovr ? !pad_sw[BIT_CLOCK_OE] :
                        clock_ser ? i_i2c_clock_oe : i_dl_clock_oe; // R3 R14
   wire hp_ovr = pad_route[BIT_HOTPLUG_OVR];
   wire cc_ovr = pad_route[BIT_CONSUMER_OVR];
   wire next_hp_out = hp_ovr ? pad_sw[BIT_HOTPLUG_LVL] : i_dl_hotplug_out; // R4
   wire next_hp_oe = hp_ovr ? !pad_sw[BIT_HOTPLUG_OE] : i_dl_hotplug_oe; // R4 R14
   wire next_cc_out = cc_ovr ? pad_sw[BIT_CONSUMER_LVL] : i_dl_consumer_out; // R5
   wire next_cc_oe = cc_ovr ? !pad_sw[BIT_CONSUMER_OE] : i_dl_consumer_oe; // R5 R14
   wire [1:0] stby_sel = pad_route[STANDBY_LSB +: 2];
   wire next_standby = (stby_sel == STBY_SIGNAL) ? i_disp_standby :
                       (stby_sel == STBY_CLK_EN) ? i_disp_bus_clk_en :
                       (stby_sel == STBY_EITHER) ? (i_disp_standby | i_disp_bus_clk_en) :
                       1'b0; // R7

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_data_pad_5v_out <= 1'b0;
         o_data_pad_5v_oe <= 1'b0;
         o_clock_pad_5v_out <= 1'b0;
         o_clock_pad_5v_oe <= 1'b0;
         o_hotplug_pad_5v_out <= 1'b0;
         o_hotplug_pad_5v_oe <= 1'b0;
         o_consumer_ctl_pad_5v_out <= 1'b0;
         o_consumer_ctl_pad_5v_oe <= 1'b0;
         o_disp_standby <= 1'b0;
         o_sram_owner_select <= 1'b0;
         o_phy_pll_power_down <= 1'b0;
         o_phy_pdata_en <= 1'b0;
         o_uart_rts_pol <= 3'h0;
         o_uart_cts_pol <= 3'h0;
         o_soc_control_four <= RESET_VALUE;
         o_pad_level <= 4'h0;
      end
      else
      begin
         o_data_pad_5v_out <= next_data_out;
         o_data_pad_5v_oe <= next_data_oe;
         o_clock_pad_5v_out <= next_clock_out;
         o_clock_pad_5v_oe <= next_clock_oe;
         o_hotplug_pad_5v_out <= next_hp_out;
         o_hotplug_pad_5v_oe <= next_hp_oe;
         o_consumer_ctl_pad_5v_out <= next_cc_out;
         o_consumer_ctl_pad_5v_oe <= next_cc_oe;
         o_disp_standby <= next_standby;
         o_sram_owner_select <= pad_route[BIT_SRAM_OWNER]; // R6
         o_phy_pll_power_down <= pad_route[BIT_PLL_PD]; // R8
         o_phy_pdata_en <= pad_route[BIT_PDATA_EN]; // R9
         o_uart_rts_pol <= pad_route[RTS_LSB +: 3]; // R10
         o_uart_cts_pol <= pad_route[CTS_LSB +: 3]; // R11
         o_soc_control_four <= soc_four; // R12
         o_pad_level <= pad_lvl;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   property p_mask_write;
      wr_route |=> pad_route == (($past(pad_route) & ~($past(i_hwdata[31:16]) & 16'hFFBF))
         | ($past(i_hwdata[15:0]) & $past(i_hwdata[31:16]) & 16'hFFBF));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("masked write wrong"); // R1

   property p_data_sw;
      pad_route[15] |=> o_data_pad_5v_oe == !$past(pad_sw[4]) && o_data_pad_5v_out == $past(pad_sw[5]);
   endproperty
   a_data_sw: assert property (p_data_sw) else $error("data pad not software driven"); // R2

   property p_clock_ser;
      !pad_route[14] && pad_sw[9] |=> o_clock_pad_5v_oe == $past(i_i2c_clock_oe);
   endproperty
   a_clock_ser: assert property (p_clock_ser) else $error("clock pad not serial owned"); // R3

   property p_hotplug_link;
      !pad_route[13] |=> o_hotplug_pad_5v_out == $past(i_dl_hotplug_out);
   endproperty
   a_hotplug_link: assert property (p_hotplug_link) else $error("hot-plug not link owned"); // R4

   property p_consumer_sw;
      pad_route[12] |=> o_consumer_ctl_pad_5v_out == $past(pad_sw[3]);
   endproperty
   a_consumer_sw: assert property (p_consumer_sw) else $error("consumer pad wrong"); // R5

   property p_sram;
      wr_route && i_hwdata[MASK_LSB + BIT_SRAM_OWNER] |=> ##1
         o_sram_owner_select == $past(i_hwdata[BIT_SRAM_OWNER], 2);
   endproperty
   a_sram: assert property (p_sram) else $error("SRAM owner wrong"); // R6

   property p_standby_or;
      pad_route[10:9] == 2'h2 |=> o_disp_standby == $past(i_disp_standby | i_disp_bus_clk_en);
   endproperty
   a_standby_or: assert property (p_standby_or) else $error("standby source wrong"); // R7

   property p_pll;
      wr_route && i_hwdata[MASK_LSB + BIT_PLL_PD] |=> ##1
         o_phy_pll_power_down == $past(i_hwdata[BIT_PLL_PD], 2);
   endproperty
   a_pll: assert property (p_pll) else $error("PLL power-down wrong"); // R8

   property p_four;
      wr_four |=> ##1 o_soc_control_four == $past(soc_four);
   endproperty
   a_four: assert property (p_four) else $error("second register not decoded"); // R12

   property p_read_zero;
      addr_take && !i_hwrite && i_haddr == OFF_PAD_ROUTE |=> o_hrdata[31:16] == 16'h0000
         && !o_hrdata[6];
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("reserved bits read non-zero"); // R15

   property p_pdata;
      wr_route && i_hwdata[MASK_LSB + BIT_PDATA_EN] |=> ##1
         o_phy_pdata_en == $past(i_hwdata[BIT_PDATA_EN], 2);
   endproperty
   a_pdata: assert property (p_pdata) else $error("parallel data enable wrong"); // R9

   property p_uart_pol;
      wr_route && i_hwdata[21:16] == 6'h3F |=> ##1
         {o_uart_rts_pol, o_uart_cts_pol} == $past(i_hwdata[5:0], 2);
   endproperty
   a_uart_pol: assert property (p_uart_pol) else $error("UART polarity wrong"); // R10 R11

   property p_hotplug_sw;
      pad_route[BIT_HOTPLUG_OVR] |=> o_hotplug_pad_5v_oe == !$past(pad_sw[BIT_HOTPLUG_OE])
         && o_hotplug_pad_5v_out == $past(pad_sw[BIT_HOTPLUG_LVL]);
   endproperty
   a_hotplug_sw: assert property (p_hotplug_sw) else $error("hot-plug not software driven"); // R4 R14

   property p_standby_rsvd;
      pad_route[10:9] == 2'h3 |=> !o_disp_standby;
   endproperty
   a_standby_rsvd: assert property (p_standby_rsvd) else $error("reserved standby not low"); // R7

   c_write_route: cover property (wr_route && i_hwdata[31]);
   c_read_four: cover property (addr_take && !i_hwrite && i_haddr == OFF_SOC_FOUR);
   c_data_sw: cover property (pad_route[15] && pad_sw[5]);
   c_standby_or: cover property (pad_route[10:9] == 2'h2);
   c_uart_all: cover property (wr_route && i_hwdata[21:16] == 6'h3F);
endmodule : soc_pad_route_control_reg
`default_nettype wire

/* tb_top.sv */
/*
 Self-checking bench of the pad routing and display control register bank.
 Assumes a zero wait state AHB-Lite slave and registered control outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pad_route_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] dl_v = 8'hB2;
   logic [3:0] i2c_v = 4'h6;
   logic [3:0] pad_in = 4'h0;
   logic sb = 1'b0;
   logic ck_en = 1'b0;
   wire logic [31:0] hrdata;
   wire logic hready;
   wire logic hresp;
   wire logic [3:0] pad_level;
   wire logic [7:0] pads;
   wire logic disp_sb;
   wire logic sram;
   wire logic pll;
   wire logic pdata;
   wire logic [2:0] rts;
   wire logic [2:0] cts;
   wire logic [15:0] four;
   int mismatches = 0;
   int total_checks = 0;

   always #50 i_clk = ~i_clk;

   soc_pad_route_control_reg soc_pad_route_control_reg_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_dl_data_out(dl_v[7]), .i_dl_data_oe(dl_v[6]), .i_dl_clock_out(dl_v[5]),
      .i_dl_clock_oe(dl_v[4]), .i_dl_hotplug_out(dl_v[3]), .i_dl_hotplug_oe(dl_v[2]),
      .i_dl_consumer_out(dl_v[1]), .i_dl_consumer_oe(dl_v[0]),
      .i_i2c_data_out(i2c_v[3]), .i_i2c_data_oe(i2c_v[2]),
      .i_i2c_clock_out(i2c_v[1]), .i_i2c_clock_oe(i2c_v[0]),
      .i_pad_in(pad_in), .o_pad_level(pad_level),
      .o_data_pad_5v_out(pads[7]), .o_data_pad_5v_oe(pads[6]),
      .o_clock_pad_5v_out(pads[5]), .o_clock_pad_5v_oe(pads[4]),
      .o_hotplug_pad_5v_out(pads[3]), .o_hotplug_pad_5v_oe(pads[2]),
      .o_consumer_ctl_pad_5v_out(pads[1]), .o_consumer_ctl_pad_5v_oe(pads[0]),
      .i_disp_standby(sb), .i_disp_bus_clk_en(ck_en), .o_disp_standby(disp_sb),
      .o_sram_owner_select(sram), .o_phy_pll_power_down(pll), .o_phy_pdata_en(pdata),
      .o_uart_rts_pol(rts), .o_uart_cts_pol(cts), .o_soc_control_four(four));

   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1)
      begin
         mismatches++;
         complete_run();
      end
   endtask : wait_ready

   task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge i_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(a, 1'b1, d, rd);
   endtask : wr

   task automatic rdck(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(a, 1'b0, 32'h0, rd);
      check(rd, exp);
   endtask : rdck

   task automatic settle;
      repeat (3) @(posedge i_clk);
   endtask : settle

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      logic [7:0] d;
      logic [7:0] p;
      logic [7:0] ex;
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
      rdck(OFF_PAD_ROUTE, 32'h0);
      rdck(OFF_SOC_FOUR, 32'h0);
      check({disp_sb, sram, pll, pdata, rts, cts}, 32'h0);
      wr(OFF_PAD_ROUTE, 32'h00FF_FFFF);
      rdck(OFF_PAD_ROUTE, 32'h0000_00BF);
      settle();
      check({pll, pdata, rts, cts}, 32'h0000_007F);
      wr(OFF_PAD_ROUTE, 32'h0100_0100);
      wr(OFF_PAD_ROUTE, 32'h003F_0000);
      settle();
      check({pll, pdata, rts, cts}, 32'h0000_00C0);
      rdck(OFF_PAD_ROUTE, 32'h0000_0180);
      wr(OFF_PAD_ROUTE, 32'h0800_0800);
      settle();
      check(sram, 32'h1);
      wr(OFF_PAD_ROUTE, 32'h0800_0000);
      settle();
      check(sram, 32'h0);
      for (int c = 0; c < 4; c++)
      begin
         wr(OFF_PAD_ROUTE, 32'h0600_0000 | (32'(c) << 9));
         for (int s = 0; s < 4; s++)
         begin
            sb <= s[0];
            ck_en <= s[1];
            settle();
            check(disp_sb, (c == 0) ? s[0] : (c == 1) ? s[1] : (c == 2) ? (s[0] | s[1]) : 1'b0);
         end
      end
      p = 8'h5A;
      wr(OFF_PAD_SW, 32'h00FF_005A);
      for (int m = 0; m < 3; m++)
      begin
         if (m == 1)
            wr(OFF_PAD_SW, 32'h0300_0300);
         if (m == 2)
            wr(OFF_PAD_ROUTE, 32'hF000_F000);
         for (int k = 0; k < 2; k++)
         begin
            d = (k == 1) ? 8'h4D : 8'hB2;
            dl_v <= d;
            i2c_v <= ~d[7:4];
            settle();
            ex = (m == 0) ? d : (m == 1) ? {~d[7:4], d[3:0]} :
               {p[5], ~p[4], p[7], ~p[6], p[1], ~p[0], p[3], ~p[2]};
            check(pads, ex);
         end
      end
      pad_in <= 4'hA;
      repeat (8) @(posedge i_clk);
      check(pad_level, 32'hA);
      rdck(OFF_PAD_SW, 32'h0000_A35A);
      wr(OFF_SOC_FOUR, 32'hFFFF_A5C3);
      rdck(OFF_SOC_FOUR, 32'h0000_A5C3);
      wr(OFF_SOC_FOUR, 32'h00F0_0000);
      rdck(OFF_SOC_FOUR, 32'h0000_A503);
      settle();
      check(four, 32'hA503);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
      rdck(OFF_PAD_ROUTE, 32'h0);
      rdck(OFF_SOC_FOUR, 32'h0);
      check({pll, sram, pdata, four}, 32'h0);
      rdck(12'h500, 32'h0);
      check(hresp, 32'h0);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
